// *** hdl/fpm_pkg.sv ***
package fpm_pkg;

  // Clock and link rates.
  localparam int unsigned CLK_HZ    = 125_000_000;
  localparam int unsigned BAUD_115K = 115_200;
  localparam int unsigned BAUD_250K = 250_000;
  localparam int unsigned BAUD_500K = 500_000;
  localparam int unsigned BAUD_1M   = 1_000_000;
  localparam logic [10:0] DIV_115K  = 11'(CLK_HZ / BAUD_115K);
  localparam logic [10:0] DIV_250K  = 11'(CLK_HZ / BAUD_250K);
  localparam logic [10:0] DIV_500K  = 11'(CLK_HZ / BAUD_500K);
  localparam logic [10:0] DIV_1M    = 11'(CLK_HZ / BAUD_1M);

  // Register map.
  localparam logic [19:0] EVCTL_IDX   = 20'hFFFBE;
  localparam logic [31:0] EVCTL_ADDR  = {10'h000, EVCTL_IDX, 2'b00};
  localparam logic [31:0] STATUS_ADDR = 32'h003F_FEFC;
  localparam logic [7:0]  EVCTL_RST   = 8'h00;
  localparam int          PUP_BIT     = 7;

  // Mode sampling delay after reset release, covering the synchroniser.
  localparam logic [1:0] BOOT_WAIT = 2'h2;

  // Link bytes.
  localparam logic [7:0] RSP_ACK         = 8'h06;
  localparam logic [7:0] RSP_NAK         = 8'h15;
  localparam logic [7:0] CMD_RESET       = 8'h00;
  localparam logic [7:0] CMD_VERIFY      = 8'h13;
  localparam logic [7:0] CMD_CHIP_ERASE  = 8'h20;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h22;
  localparam logic [7:0] CMD_BLANK_CHECK = 8'h32;
  localparam logic [7:0] CMD_PROGRAM     = 8'h40;
  localparam logic [7:0] CMD_SECURITY    = 8'hA0;
  localparam logic [7:0] CMD_CHECKSUM    = 8'hB0;
  localparam logic [7:0] CMD_SIGNATURE   = 8'hC0;
  localparam logic [7:0] CMD_VERSION     = 8'hC5;
  localparam logic [7:0] CMD_BAUD_SET    = 8'h9A;
  localparam logic [7:0] ERASED          = 8'hFF;

  // Security bits.
  localparam int SEC_CHIP = 0;
  localparam int SEC_BLK  = 1;
  localparam int SEC_WR   = 2;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } fpm_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } fpm_ahb_rsp_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} fpm_rx_t;
  typedef enum logic [2:0] {
    CS_IDLE, CS_ARG_A, CS_ARG_L, CS_ARG_X, CS_DATA, CS_VRD, CS_WALK, CS_SEND
  } fpm_cs_t;

  typedef struct packed {
    logic [1:0]  boot_cnt;
    logic        sampled;
    logic        prog;
    logic        fl_s1;
    logic        fl_s2;
    logic        rx_s1;
    logic        rx_s2;
    logic [7:0]  evctl;
    logic [7:0]  sec;
    logic        dp_wr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    fpm_rx_t     rx;
    logic [10:0] rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_vld;
    logic        rx_ferr;
    logic        tx_busy;
    logic [9:0]  tx_sh;
    logic [10:0] tx_cnt;
    logic [3:0]  tx_bits;
    logic        tx_line;
    logic        oe_n;
    logic [10:0] div;
    logic [10:0] div_pend;
    logic        baud_pend;
    fpm_cs_t     cs;
    fpm_cs_t     ret;
    logic [7:0]  cmd;
    logic [7:0]  addr;
    logic [8:0]  cnt;
    logic        phase;
    logic [15:0] csum;
    logic        flag;
    logic [31:0] pay;
    logic [2:0]  pay_n;
  } fpm_state_t;

endpackage

// *** hdl/fpm_mem.sv ***
`timescale 1ns/100ps
module fpm_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock.
  input  wire logic          sys_clk_in,
  // Access.
  input  wire logic [AW-1:0] addr_in,
  input  wire logic          we_in,
  input  wire logic [DW-1:0] wdata_in,
  output logic      [DW-1:0] rdata_out
);
  logic [DW-1:0] mem_ff [0:(1<<AW)-1];
  logic [DW-1:0] rdata_ff;

  // Read data is the old word during a write, like a real array.
  always_ff @(posedge sys_clk_in)
  begin
    if (we_in)
    begin
      mem_ff[addr_in] <= wdata_in;
    end
    rdata_ff <= mem_ff[addr_in];
  end

  assign rdata_out = rdata_ff;
endmodule // fpm_mem

// *** hdl/fpm_cmd_if.sv ***
`timescale 1ns/100ps
module fpm_cmd_if #(
  parameter logic [7:0] SIG_CODE   = 8'hA5, // Arbitrary value.
  parameter logic [7:0] FW_VERSION = 8'h01  // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_in,
  // Register bus.
  input  wire fpm_pkg::fpm_ahb_req_t ahb_req_in,
  output fpm_pkg::fpm_ahb_rsp_t      ahb_rsp_out,
  // Mode and tool pins.
  input  wire logic                  mode_select_pin_in,
  input  wire logic                  tool_serial_pin_in,
  output logic                       tool_serial_pin_out,
  output logic                       tool_serial_pin_oe_n_out,
  // Chip-level controls.
  output logic                       mode_pin_pullup_select_out,
  output logic                       prog_mode_out,
  output logic                       port_hold_out,
  output logic                       osc_internal_sel_out
);
  import fpm_pkg::*;

  fpm_state_t st;
  fpm_state_t nxt;
  logic       mem_we;
  logic [7:0] mem_wd;
  logic [7:0] mem_addr;
  logic [7:0] mem_rd;

  fpm_mem #(
    .AW (8),
    .DW (8)
  ) u_mem (
    .sys_clk_in (sys_clk_in),
    .addr_in    (mem_addr),
    .we_in      (mem_we),
    .wdata_in   (mem_wd),
    .rdata_out  (mem_rd)
  );

  function automatic fpm_state_t queue(input fpm_state_t s, input logic [31:0] p,
                                       input logic [2:0] n, input fpm_cs_t r);
    fpm_state_t t;
    t       = s;
    t.pay   = p;
    t.pay_n = n;
    t.ret   = r;
    t.cs    = CS_SEND;
    return t;
  endfunction

  always_comb
  begin
    logic [15:0] sum_v;
    logic        ok_v;
    fpm_cs_t     after_v;
    sum_v    = st.csum + 16'(mem_rd);
    ok_v     = st.flag && (mem_rd == ERASED);
    after_v  = (st.cnt == 9'h001) ? CS_IDLE : CS_DATA;
    nxt      = st;
    mem_we   = 1'b0;
    mem_wd   = ERASED;
    mem_addr = st.addr;
    nxt.rx_vld  = 1'b0;
    nxt.rx_ferr = 1'b0;
    nxt.fl_s1   = mode_select_pin_in;
    nxt.fl_s2   = st.fl_s1;
    nxt.rx_s1   = tool_serial_pin_in;
    nxt.rx_s2   = st.rx_s1;

    // The mode is caught once, after the synchroniser has filled.
    if (!st.sampled)
    begin
      nxt.boot_cnt = st.boot_cnt + 2'h1;
      if (st.boot_cnt == BOOT_WAIT)
      begin
        nxt.sampled = 1'b1;
        nxt.prog    = st.fl_s2;
      end
    end

    // Zero-wait bus slave; write data lands in the data phase.
    nxt.hreadyout = 1'b1;
    nxt.hresp     = 1'b0;
    nxt.dp_wr     = 1'b0;
    if (st.dp_wr)
    begin
      nxt.evctl = {ahb_req_in.hwdata[PUP_BIT], 7'h00};
    end
    if (ahb_req_in.hsel && ahb_req_in.hready && ahb_req_in.htrans[1])
    begin
      nxt.dp_wr = ahb_req_in.hwrite && ({ahb_req_in.haddr[31:2], 2'b00} == EVCTL_ADDR);
      if (!ahb_req_in.hwrite)
      begin
        case ({ahb_req_in.haddr[31:2], 2'b00})
          EVCTL_ADDR:  nxt.hrdata = {24'h000000, nxt.evctl};
          STATUS_ADDR: nxt.hrdata = {16'h0000, st.sec, 5'h00, st.baud_pend,
                                     st.cs != CS_IDLE, st.prog};
          default:     nxt.hrdata = 32'h0000_0000;
        endcase
      end
    end

    // Receiver, idle while the device talks on the shared wire.
    case (st.rx)
      RX_IDLE:
      begin
        if (st.prog && !st.tx_busy && st.cs != CS_SEND && !st.rx_s2)
        begin
          nxt.rx     = RX_START;
          nxt.rx_cnt = {1'b0, st.div[10:1]};
        end
      end
      RX_START:
      begin
        if (st.rx_cnt != 11'h000)
        begin
          nxt.rx_cnt = st.rx_cnt - 11'h001;
        end
        else if (st.rx_s2)
        begin
          nxt.rx = RX_IDLE;
        end
        else
        begin
          nxt.rx     = RX_DATA;
          nxt.rx_cnt = st.div - 11'h001;
          nxt.rx_bit = 3'h0;
        end
      end
      RX_DATA:
      begin
        if (st.rx_cnt != 11'h000)
        begin
          nxt.rx_cnt = st.rx_cnt - 11'h001;
        end
        else
        begin
          nxt.rx_sh  = {st.rx_s2, st.rx_sh[7:1]};
          nxt.rx_cnt = st.div - 11'h001;
          nxt.rx_bit = st.rx_bit + 3'h1;
          if (st.rx_bit == 3'h7)
          begin
            nxt.rx = RX_STOP;
          end
        end
      end
      RX_STOP:
      begin
        if (st.rx_cnt != 11'h000)
        begin
          nxt.rx_cnt = st.rx_cnt - 11'h001;
        end
        else
        begin
          nxt.rx      = RX_IDLE;
          nxt.rx_vld  = st.rx_s2;
          nxt.rx_ferr = !st.rx_s2;
        end
      end
      default: nxt.rx = RX_IDLE;
    endcase

    // Transmitter: start, eight data bits, stop, then the wire is released.
    if (st.tx_busy)
    begin
      if (st.tx_cnt != 11'h000)
      begin
        nxt.tx_cnt = st.tx_cnt - 11'h001;
      end
      else if (st.tx_bits == 4'h0)
      begin
        nxt.tx_busy = 1'b0;
        nxt.oe_n    = 1'b1;
      end
      else
      begin
        nxt.tx_line = st.tx_sh[0];
        nxt.tx_sh   = {1'b1, st.tx_sh[9:1]};
        nxt.tx_bits = st.tx_bits - 4'h1;
        nxt.tx_cnt  = st.div - 11'h001;
      end
    end

    // A new rate takes effect only after its own ACK has left.
    if (st.cs == CS_IDLE && !st.tx_busy && st.baud_pend)
    begin
      nxt.div       = st.div_pend;
      nxt.baud_pend = 1'b0;
    end

    case (st.cs)
      CS_IDLE:
      begin
        if (st.rx_ferr)
        begin
          nxt = queue(nxt, {RSP_NAK, 24'h000000}, 3'h1, CS_IDLE);
        end
        else if (st.rx_vld)
        begin
          nxt.cmd = st.rx_sh;
          case (st.rx_sh)
            CMD_RESET:
              nxt = queue(nxt, {RSP_ACK, 24'h000000}, 3'h1, CS_IDLE);
            CMD_CHIP_ERASE:
            begin
              if (st.sec[SEC_CHIP])
              begin
                nxt = queue(nxt, {RSP_NAK, 24'h000000}, 3'h1, CS_IDLE);
              end
              else
              begin
                nxt.addr = 8'h00;
                nxt.cnt  = 9'h100;
                nxt.sec  = 8'h00;
                nxt.cs   = CS_WALK;
              end
            end
            CMD_BLOCK_ERASE, CMD_BLANK_CHECK, CMD_PROGRAM, CMD_VERIFY, CMD_CHECKSUM:
              nxt.cs = CS_ARG_A;
            CMD_SIGNATURE:
              nxt = queue(nxt, {RSP_ACK, SIG_CODE, 8'hFF, 8'h00}, 3'h3, CS_IDLE);
            CMD_VERSION:
              nxt = queue(nxt, {RSP_ACK, FW_VERSION, 16'h0000}, 3'h2, CS_IDLE);
            CMD_SECURITY, CMD_BAUD_SET:
              nxt.cs = CS_ARG_X;
            default:
              nxt = queue(nxt, {RSP_NAK, 24'h000000}, 3'h1, CS_IDLE);
          endcase
        end
      end
      CS_ARG_A:
      begin
        if (st.rx_ferr)
        begin
          nxt = queue(nxt, {RSP_NAK, 24'h000000}, 3'h1, CS_IDLE);
        end
        else if (st.rx_vld)
        begin
          nxt.addr = st.rx_sh;
          nxt.cs   = CS_ARG_L;
        end
      end
      CS_ARG_L:
      begin
        nxt.cnt   = {1'b0, st.rx_sh} + 9'h001;
        nxt.csum  = 16'h0000;
        nxt.flag  = 1'b1;
        nxt.phase = 1'b0;
        if (st.rx_ferr)
        begin
          nxt = queue(nxt, {RSP_NAK, 24'h000000}, 3'h1, CS_IDLE);
        end
        else if (st.rx_vld)
        begin
          // An area running past the array end is a malformed frame.
          if ({1'b0, st.addr} + {1'b0, st.rx_sh} > 9'h0FF)
          begin
            nxt = queue(nxt, {RSP_NAK, 24'h000000}, 3'h1, CS_IDLE);
          end
          else if (st.cmd == CMD_PROGRAM)
          begin
            nxt = queue(nxt, {st.sec[SEC_WR] ? RSP_NAK : RSP_ACK, 24'h000000}, 3'h1,
                        st.sec[SEC_WR] ? CS_IDLE : CS_DATA);
          end
          else if (st.cmd == CMD_VERIFY)
          begin
            nxt = queue(nxt, {RSP_ACK, 24'h000000}, 3'h1, CS_DATA);
          end
          else if (st.cmd == CMD_BLOCK_ERASE && (st.sec[SEC_BLK] || st.sec[SEC_WR]))
          begin
            nxt = queue(nxt, {RSP_NAK, 24'h000000}, 3'h1, CS_IDLE);
          end
          else
          begin
            nxt.cs = CS_WALK;
          end
        end
      end
      CS_ARG_X:
      begin
        if (st.rx_ferr)
        begin
          nxt = queue(nxt, {RSP_NAK, 24'h000000}, 3'h1, CS_IDLE);
        end
        else if (st.rx_vld && st.cmd == CMD_SECURITY)
        begin
          nxt.sec = st.sec | st.rx_sh;
          nxt     = queue(nxt, {RSP_ACK, 24'h000000}, 3'h1, CS_IDLE);
        end
        else if (st.rx_vld)
        begin
          nxt.baud_pend = (st.rx_sh < 8'h04);
          case (st.rx_sh[1:0])
            2'h0:    nxt.div_pend = DIV_115K;
            2'h1:    nxt.div_pend = DIV_250K;
            2'h2:    nxt.div_pend = DIV_500K;
            default: nxt.div_pend = DIV_1M;
          endcase
          nxt = queue(nxt, {(st.rx_sh < 8'h04) ? RSP_ACK : RSP_NAK, 24'h000000}, 3'h1,
                      CS_IDLE);
        end
      end
      CS_DATA:
      begin
        if (st.rx_ferr)
        begin
          nxt = queue(nxt, {RSP_NAK, 24'h000000}, 3'h1, CS_IDLE);
        end
        else if (st.rx_vld && st.cmd == CMD_PROGRAM)
        begin
          mem_we   = 1'b1;
          mem_wd   = st.rx_sh;
          nxt.addr = st.addr + 8'h01;
          nxt.cnt  = st.cnt - 9'h001;
          nxt      = queue(nxt, {RSP_ACK, 24'h000000}, 3'h1, after_v);
        end
        else if (st.rx_vld)
        begin
          nxt.csum = {8'h00, st.rx_sh};
          nxt.cs   = CS_VRD;
        end
      end
      CS_VRD:
      begin
        nxt.addr = st.addr + 8'h01;
        nxt.cnt  = st.cnt - 9'h001;
        nxt = queue(nxt, {(mem_rd == st.csum[7:0]) ? RSP_ACK : RSP_NAK, 24'h000000}, 3'h1,
                    after_v);
      end
      CS_WALK:
      begin
        if (st.cmd == CMD_CHIP_ERASE || st.cmd == CMD_BLOCK_ERASE)
        begin
          mem_we   = 1'b1;
          nxt.addr = st.addr + 8'h01;
          nxt.cnt  = st.cnt - 9'h001;
          if (st.cnt == 9'h001)
          begin
            nxt = queue(nxt, {RSP_ACK, 24'h000000}, 3'h1, CS_IDLE);
          end
        end
        else if (!st.phase)
        begin
          nxt.phase = 1'b1;
        end
        else
        begin
          // Reads take two cycles each since the array output is registered.
          nxt.phase = 1'b0;
          nxt.flag  = ok_v;
          nxt.csum  = sum_v;
          nxt.addr  = st.addr + 8'h01;
          nxt.cnt   = st.cnt - 9'h001;
          if (st.cnt == 9'h001 && st.cmd == CMD_BLANK_CHECK)
          begin
            nxt = queue(nxt, {ok_v ? RSP_ACK : RSP_NAK, 24'h000000}, 3'h1, CS_IDLE);
          end
          else if (st.cnt == 9'h001)
          begin
            nxt = queue(nxt, {RSP_ACK, sum_v, 8'h00}, 3'h3, CS_IDLE);
          end
        end
      end
      CS_SEND:
      begin
        if (!st.tx_busy && st.rx == RX_IDLE)
        begin
          if (st.pay_n == 3'h0)
          begin
            nxt.cs = st.ret;
          end
          else
          begin
            nxt.tx_sh   = {1'b1, st.pay[31:24], 1'b0};
            nxt.tx_bits = 4'hA;
            nxt.tx_cnt  = 11'h000;
            nxt.tx_busy = 1'b1;
            nxt.oe_n    = 1'b0;
            nxt.pay     = {st.pay[23:0], 8'h00};
            nxt.pay_n   = st.pay_n - 3'h1;
          end
        end
      end
      default: nxt.cs = CS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      st           <= '0;
      st.evctl     <= EVCTL_RST;
      st.hreadyout <= 1'b1;
      st.tx_line   <= 1'b1;
      st.oe_n      <= 1'b1;
      st.div       <= DIV_1M;
      st.div_pend  <= DIV_1M;
    end
    else
    begin
      st <= nxt;
    end
  end

  assign ahb_rsp_out                = '{hrdata: st.hrdata, hreadyout: st.hreadyout,
                                        hresp: st.hresp};
  assign tool_serial_pin_out        = st.tx_line;
  assign tool_serial_pin_oe_n_out   = st.oe_n;
  assign mode_pin_pullup_select_out = st.evctl[PUP_BIT];
  assign prog_mode_out              = st.prog;
  assign port_hold_out              = st.prog;
  assign osc_internal_sel_out       = st.prog;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  chk_evctl_reset: assert property ($fell(rst_in) |-> st.evctl == EVCTL_RST)
    else $error("Event control register not zero after reset.");
  chk_pullup_write: assert property (st.dp_wr |=>
    mode_pin_pullup_select_out == $past(ahb_req_in.hwdata[PUP_BIT]))
    else $error("Pull-up select does not follow bit 7 of the write.");
  chk_mode_frozen: assert property (st.sampled |=> $stable(prog_mode_out))
    else $error("Operating mode changed after it was sampled.");
  chk_prog_pins: assert property (prog_mode_out |-> port_hold_out && osc_internal_sel_out)
    else $error("Programming mode without pin hold or internal clock.");
  chk_no_drive: assert property (!prog_mode_out |-> tool_serial_pin_oe_n_out)
    else $error("Serial pin driven outside programming mode.");
  chk_ferr_nak: assert property (st.cs == CS_IDLE && st.rx_ferr |=>
    st.cs == CS_SEND && st.pay[31:24] == RSP_NAK && st.pay_n == 3'h1)
    else $error("Malformed frame not answered with NAK.");
  chk_reset_ack: assert property (st.cs == CS_IDLE && st.rx_vld && st.rx_sh == CMD_RESET
    |=> st.pay[31:24] == RSP_ACK && st.pay_n == 3'h1)
    else $error("Reset command not acknowledged.");
  chk_chip_walk: assert property (st.cs == CS_IDLE && st.rx_vld && st.rx_sh == CMD_CHIP_ERASE
    && !st.sec[SEC_CHIP] |=> st.cs == CS_WALK && st.cnt == 9'h100)
    else $error("Chip erase does not walk the whole array.");
  chk_prog_write: assert property (st.cs == CS_DATA && st.rx_vld && st.cmd == CMD_PROGRAM
    |-> mem_we && mem_wd == st.rx_sh)
    else $error("Programming data not written.");
  chk_sig_len: assert property (st.cs == CS_IDLE && st.rx_vld && st.rx_sh == CMD_SIGNATURE
    |=> st.pay_n == 3'h3 ##1 st.tx_busy && st.pay_n == 3'h2)
    else $error("Signature answer has wrong length.");
  chk_baud_apply: assert property (st.cs == CS_IDLE && !st.tx_busy && st.baud_pend
    |=> st.div == $past(st.div_pend) && !st.baud_pend)
    else $error("Pending link rate not applied.");
  chk_baud_range: assert property (st.div >= DIV_1M && st.div <= DIV_115K)
    else $error("Link rate out of range.");
  chk_half_duplex: assert property (st.tx_busy |-> st.rx == RX_IDLE)
    else $error("Receiver active while transmitting.");

  cov_prog_entry: cover property ($rose(prog_mode_out));
  cov_prog_write: cover property (mem_we && st.cmd == CMD_PROGRAM);
  cov_chip_erase: cover property (st.cs == CS_WALK && st.cmd == CMD_CHIP_ERASE);
  cov_baud_set:   cover property ($changed(st.div));
endmodule // fpm_cmd_if

// *** testbench/fpm_prog_model.sv ***
`timescale 1ns/100ps
// Programmer end of the single-wire link, 8N1 and LSB first.
module fpm_prog_model (
  // Clock and wire.
  input  wire logic sys_clk_in,
  input  wire logic line_in,
  // Drive.
  output logic      tx_out,
  output logic      tx_oe_n_out
);
  int div = 125;
  // Released outside frames, so the pull-up keeps the wire high.
  initial
  begin
    tx_out = 1'b1;
    tx_oe_n_out = 1'b1;
  end
  task automatic send_byte(input logic [7:0] b, input logic stop_bit = 1'b1);
    logic [9:0] f;
    f = {stop_bit, b, 1'b0};
    @(posedge sys_clk_in);
    for (int i = 0; i < 9; i++)
    begin
      tx_out <= f[i];
      tx_oe_n_out <= 1'b0;
      repeat (div) @(posedge sys_clk_in);
    end
    // A high stop bit is left to the pull-up, because the answer may start inside it.
    tx_out <= f[9];
    tx_oe_n_out <= f[9];
    @(posedge sys_clk_in);
    for (int i = 1; i < div && (line_in !== 1'b0 || (!f[9] && i < div * 3 / 4)); i++)
      @(posedge sys_clk_in);
    tx_oe_n_out <= 1'b1;
  endtask
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (line_in !== 1'b0 && n < 40 * div)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    repeat (div / 2) @(posedge sys_clk_in);
    ok = (line_in === 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      repeat (div) @(posedge sys_clk_in);
      b[i] = line_in;
    end
    repeat (div) @(posedge sys_clk_in);
    ok = ok && (line_in === 1'b1);
    repeat (div / 2) @(posedge sys_clk_in);
  endtask
endmodule // fpm_prog_model

// *** testbench/flash_program_mode_cmd_if_test.sv ***
`timescale 1ns/100ps
module flash_program_mode_cmd_if_test;
  import fpm_pkg::*;
  localparam logic [7:0] SIG = 8'h5A; // Arbitrary value.
  localparam logic [7:0] FW  = 8'h03; // Arbitrary value.
  logic         sys_clk_in;
  logic         rst_in;
  logic         mode_pin;
  fpm_ahb_req_t mreq;
  fpm_ahb_req_t dreq;
  fpm_ahb_rsp_t rsp;
  logic         d_tx, d_oe_n, m_tx, m_oe_n, line, pup, prog, hold, osc;
  int           failures = 0;
  int           tests_run = 0;
  int           cyc = 0;
  always_comb
  begin
    dreq = mreq;
    dreq.hready = rsp.hreadyout;
  end
  // The wire has a pull-up, so it reads high when neither end drives it.
  assign line = !d_oe_n ? d_tx : (!m_oe_n ? m_tx : 1'b1);
  fpm_cmd_if #(.SIG_CODE(SIG), .FW_VERSION(FW)) dut_u (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ahb_req_in(dreq), .ahb_rsp_out(rsp),
    .mode_select_pin_in(mode_pin), .tool_serial_pin_in(line), .tool_serial_pin_out(d_tx),
    .tool_serial_pin_oe_n_out(d_oe_n), .mode_pin_pullup_select_out(pup),
    .prog_mode_out(prog), .port_hold_out(hold), .osc_internal_sel_out(osc));
  fpm_prog_model prog_u (
    .sys_clk_in(sys_clk_in), .line_in(line), .tx_out(m_tx), .tx_oe_n_out(m_oe_n));
  initial
  begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 98000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk_in);
    mreq.hsel <= 1'b1;
    mreq.haddr <= a;
    mreq.htrans <= 2'b10;
    mreq.hwrite <= w;
    @(posedge sys_clk_in);
    while (rsp.hreadyout !== 1'b1) @(posedge sys_clk_in);
    mreq.hsel <= 1'b0;
    mreq.htrans <= 2'b00;
    mreq.hwdata <= wd;
    @(posedge sys_clk_in);
    while (rsp.hreadyout !== 1'b1) @(posedge sys_clk_in);
    rd = rsp.hrdata;
  endtask
  task automatic do_reset(input logic m);
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    mode_pin <= m;
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
  endtask
  task automatic xfer(input logic [7:0] s[$], input logic [7:0] e[$]);
    logic [7:0] b;
    logic       ok;
    foreach (s[i]) prog_u.send_byte(s[i]);
    foreach (e[i])
    begin
      prog_u.recv_byte(b, ok);
      chk({23'h0, ok, b}, {23'h0, 1'b1, e[i]}, "serial reply");
    end
  endtask
  task automatic regs_test();
    logic [31:0] r;
    bus(1'b0, EVCTL_ADDR, 32'h0, r);
    chk(r, 32'h0, "event control reset");
    bus(1'b1, EVCTL_ADDR, 32'hFF, r);
    bus(1'b0, EVCTL_ADDR, 32'h0, r);
    chk(r, 32'h80, "pull-up field");
    chk(32'(pup), 32'h1, "pull-up select");
    bus(1'b1, EVCTL_ADDR, 32'h7F, r);
    bus(1'b0, 32'h0000_0100, 32'h0, r);
    chk(r, 32'h0, "unmapped read");
    chk(32'(pup), 32'h0, "pull-down select");
  endtask
  task automatic ferr_test();
    logic [7:0] b;
    logic       ok;
    prog_u.send_byte(CMD_VERSION, 1'b0);
    prog_u.recv_byte(b, ok);
    chk({23'h0, ok, b}, {23'h0, 1'b1, RSP_NAK}, "framing error");
  endtask
  task automatic status_test();
    logic [31:0] r;
    repeat (8) @(posedge sys_clk_in);
    bus(1'b0, STATUS_ADDR, 32'h0, r);
    chk(r, 32'h0000_0101, "status word");
    chk(32'(rsp.hresp), 32'h0, "bus response");
  endtask
  initial
  begin
    rst_in = 1'b1;
    mode_pin = 1'b0;
    mreq = '0;
    mreq.hsize = 3'b010;
    do_reset(1'b0);
    chk(32'({prog, hold, osc, pup}), 32'h0, "normal mode");
    regs_test();
    do_reset(1'b1);
    chk(32'({prog, hold, osc}), 32'h7, "programming mode");
    xfer('{CMD_RESET}, '{RSP_ACK});
    xfer('{CMD_SIGNATURE}, '{RSP_ACK, SIG, ERASED});
    xfer('{CMD_VERSION}, '{RSP_ACK, FW});
    xfer('{8'h55}, '{RSP_NAK});
    ferr_test();
    xfer('{CMD_PROGRAM, 8'h10, 8'h01}, '{RSP_ACK});
    xfer('{8'h12}, '{RSP_ACK});
    xfer('{8'h34}, '{RSP_ACK});
    xfer('{CMD_VERIFY, 8'h10, 8'h01}, '{RSP_ACK});
    xfer('{8'h12}, '{RSP_ACK});
    xfer('{8'h99}, '{RSP_NAK});
    xfer('{CMD_CHECKSUM, 8'h10, 8'h01}, '{RSP_ACK, 8'h00, 8'h46});
    xfer('{CMD_BLANK_CHECK, 8'h10, 8'h01}, '{RSP_NAK});
    xfer('{CMD_BLOCK_ERASE, 8'hF0, 8'h20}, '{RSP_NAK});
    xfer('{CMD_BLOCK_ERASE, 8'h10, 8'h01}, '{RSP_ACK});
    xfer('{CMD_BLANK_CHECK, 8'h10, 8'h01}, '{RSP_ACK});
    xfer('{CMD_CHIP_ERASE}, '{RSP_ACK});
    xfer('{CMD_SECURITY, 8'h01}, '{RSP_ACK});
    xfer('{CMD_CHIP_ERASE}, '{RSP_NAK});
    xfer('{CMD_BAUD_SET, 8'h07}, '{RSP_NAK});
    xfer('{CMD_BAUD_SET, 8'h02}, '{RSP_ACK});
    prog_u.div = 250;
    xfer('{CMD_RESET}, '{RSP_ACK});
    status_test();
    tally_and_finish();
  end
endmodule // flash_program_mode_cmd_if_test
